// [inc/vcm_pkg.sv]
// Purpose: shared constants for the actuator control block and its serial port
// Assumes: 7-bit register addresses, 8-bit register data
// Notes: mode codes are the values software writes to the mode register
package vcm_pkg;
   // register offsets
   localparam logic [6:0] REG_CAL_STATUS = 7'h00;
   localparam logic [6:0] REG_MODE = 7'h03;
   localparam logic [6:0] REG_CMD_HIGH = 7'h09;
   localparam logic [6:0] REG_CMD_LOW = 7'h0A;
   localparam logic [6:0] REG_ADC_CTRL = 7'h0B;
   localparam logic [6:0] REG_ADC_BASE = 7'h10;
   localparam logic [6:0] REG_ADC_LAST = 7'h17;
   // field positions
   localparam int GAIN_BIT = 7;
   localparam int TRIP_BIT = 6;
   localparam int SUPPLY12_BIT = 0;
   localparam int SUPPLY5_BIT = 1;
   localparam int SCALE_BIT = 0;
   localparam int ADC_RUN_BIT = 1;
   localparam int MODE_W = 3;
   localparam int CMD_W = 15;
   localparam int ADC_W = 10;
   localparam int ADC_CHANNELS = 4;
   // reset values
   localparam logic [7:0] CMD_HIGH_RESET = 8'h00;
   localparam logic [7:0] CMD_LOW_RESET = 8'h00;
   localparam logic [7:0] ADC_CTRL_RESET = 8'h00;
   // serial frame: read flag, 7 address bits, 8 data bits, msb first
   localparam logic [4:0] HEADER_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h10;

   typedef enum logic [2:0] {
      MODE_RETRACT = 3'h0,
      MODE_TRISTATE = 3'h1,
      MODE_BRAKE = 3'h2,
      MODE_CURRENT = 3'h3,
      MODE_VOLTAGE = 3'h4,
      MODE_CALIBRATE = 3'h5
   } actuator_mode_t;

   typedef enum logic [2:0] {
      ADC_IDLE = 3'b001,
      ADC_BUSY = 3'b010,
      ADC_STORE = 3'b100
   } adc_state_t;
endpackage : vcm_pkg

// [rtl/serial_reg_port.sv]
// Purpose: three-wire serial register port, sampled by the core clock
// Assumes: enable high frames a transfer; data taken on serial clock rise
// Notes: read data leaves on serial clock fall, msb first
`timescale 1ns/100ps
`default_nettype none
module serial_reg_port
   import vcm_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_enable_i,
   input wire logic serial_data_i,
   input wire logic [7:0] rd_data_i,
   output logic serial_data_o,
   output logic serial_data_oe_n_o,
   output logic [6:0] addr_o,
   output logic [7:0] wr_data_o,
   output logic wr_strobe_o,
   output logic rd_strobe_o
);
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic clk_d;
   logic [4:0] bit_cnt;
   logic [14:0] shift_in;
   logic [7:0] shift_out;
   logic reading;
   logic drive;
   logic [4:0] next_bit_cnt;
   logic [14:0] next_shift_in;
   logic [7:0] next_shift_out;
   logic next_reading;
   logic next_drive;
   logic [6:0] next_addr;
   logic [7:0] next_wr_data;
   logic next_wr_strobe;
   logic next_rd_strobe;
   logic rise;
   logic fall;
   logic [7:0] header;
   logic [15:0] full;

   // pins are asynchronous to the core clock
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         clk_d <= 1'b0;
      end else begin
         sync1 <= {serial_data_i, serial_enable_i, serial_clk_i};
         sync2 <= sync1;
         clk_d <= sync2[0];
      end
   end

   assign rise = sync2[0] & ~clk_d;
   assign fall = ~sync2[0] & clk_d;
   assign header = {shift_in[6:0], sync2[2]};
   assign full = {shift_in, sync2[2]};

   always_comb begin
      next_bit_cnt = bit_cnt;
      next_shift_in = shift_in;
      next_shift_out = shift_out;
      next_reading = reading;
      next_drive = drive;
      next_addr = addr_o;
      next_wr_data = wr_data_o;
      next_wr_strobe = 1'b0;
      next_rd_strobe = 1'b0;
      if (rd_strobe_o) begin
         next_shift_out = rd_data_i;
      end
      if (!sync2[1]) begin
         // frame end aborts a partial transfer with no write
         next_bit_cnt = 5'h00;
         next_reading = 1'b0;
         next_drive = 1'b0;
      end else if (rise && bit_cnt != FRAME_BITS) begin
         next_shift_in = full[14:0];
         next_bit_cnt = bit_cnt + 5'h01;
         if (bit_cnt == HEADER_BITS - 5'h01) begin
            next_addr = header[6:0];
            if (header[7]) begin
               next_reading = 1'b1;
               next_rd_strobe = 1'b1;
            end
         end
         if (bit_cnt == FRAME_BITS - 5'h01 && !reading) begin
            next_addr = full[14:8];
            next_wr_data = full[7:0];
            next_wr_strobe = 1'b1;
         end
      end else if (fall && reading) begin
         if (bit_cnt == FRAME_BITS) begin
            next_drive = 1'b0;
         end else begin
            if (drive) begin
               next_shift_out = {shift_out[6:0], 1'b0};
            end
            next_drive = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bit_cnt <= 5'h00;
         shift_in <= 15'h0000;
         shift_out <= 8'h00;
         reading <= 1'b0;
         drive <= 1'b0;
         addr_o <= 7'h00;
         wr_data_o <= 8'h00;
         wr_strobe_o <= 1'b0;
         rd_strobe_o <= 1'b0;
      end else begin
         bit_cnt <= next_bit_cnt;
         shift_in <= next_shift_in;
         shift_out <= next_shift_out;
         reading <= next_reading;
         drive <= next_drive;
         addr_o <= next_addr;
         wr_data_o <= next_wr_data;
         wr_strobe_o <= next_wr_strobe;
         rd_strobe_o <= next_rd_strobe;
      end
   end

   assign serial_data_o = shift_out[7];
   assign serial_data_oe_n_o = ~drive;
endmodule : serial_reg_port
`default_nettype wire

// [rtl/vcm_dac_mode_control.sv]
// Purpose: actuator mode, current command staging, gain and converter control
// Assumes: converter macro and comparator pins; supply flags from monitors
// Notes: registers are reached only through the three-wire serial port
`timescale 1ns/100ps
`default_nettype none
module vcm_dac_mode_control
   import vcm_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_enable_i,
   input wire logic serial_data_i,
   output logic serial_data_o,
   output logic serial_data_oe_n_o,
   input wire logic supply12_ok_i,
   input wire logic supply5_ok_i,
   input wire logic cal_comparator_i,
   input wire logic adc_done_i,
   input wire logic [ADC_W-1:0] adc_result_i,
   output logic adc_start_o,
   output logic [1:0] adc_channel_o,
   output logic converter_scale_select_o,
   output logic [CMD_W-1:0] dac_code_o,
   output logic sense_gain_select_o,
   output logic [MODE_W-1:0] actuator_mode_o,
   output logic power_stage_tristate_o,
   output logic bridge_brake_o,
   output logic retract_enable_o,
   output logic sense_amp_tristate_o,
   output logic error_amp_tristate_o,
   output logic direct_drive_switch_o,
   output logic compensation_disconnect_switch_o
);
   logic [6:0] addr;
   logic [7:0] wr_data;
   logic wr_strobe;
   logic rd_strobe;
   logic [7:0] rd_data;
   logic [MODE_W-1:0] mode_reg;
   logic [7:0] cmd_high;
   logic [7:0] cmd_low;
   logic [7:0] adc_ctrl;
   logic trip_flag;
   logic [MODE_W-1:0] next_mode_reg;
   logic [7:0] next_cmd_high;
   logic [7:0] next_cmd_low;
   logic [7:0] next_adc_ctrl;
   logic next_trip_flag;
   logic [CMD_W-1:0] next_dac_code;
   logic [2:0] async_s1;
   logic [2:0] async_s2;
   logic comp_d;
   logic supplies_ok;
   logic trip_event;
   logic [MODE_W-1:0] applied_mode;
   adc_state_t adc_state;
   adc_state_t next_adc_state;
   logic [1:0] next_adc_channel;
   logic [ADC_W-1:0] adc_mem [ADC_CHANNELS];
   logic [ADC_W-1:0] adc_low_hold;

   function automatic logic is_write(input logic stb, input logic [6:0] a,
                                     input logic [6:0] target);
      is_write = stb && (a == target);
   endfunction : is_write

   serial_reg_port port_u (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .serial_clk_i(serial_clk_i),
      .serial_enable_i(serial_enable_i),
      .serial_data_i(serial_data_i),
      .rd_data_i(rd_data),
      .serial_data_o(serial_data_o),
      .serial_data_oe_n_o(serial_data_oe_n_o),
      .addr_o(addr),
      .wr_data_o(wr_data),
      .wr_strobe_o(wr_strobe),
      .rd_strobe_o(rd_strobe)
   );

   // comparator and supply flags come from analog, outside the clock domain
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         async_s1 <= 3'h0;
         async_s2 <= 3'h0;
         comp_d <= 1'b0;
      end else begin
         async_s1 <= {cal_comparator_i, supply5_ok_i, supply12_ok_i};
         async_s2 <= async_s1;
         comp_d <= async_s2[2];
      end
   end

   assign supplies_ok = async_s2[0] & async_s2[1];
   // either swing direction counts as the trip
   assign trip_event = (async_s2[2] != comp_d) && (mode_reg == MODE_CALIBRATE);

   // assisted drive falls back to retract when a supply is missing
   always_comb begin
      applied_mode = mode_reg;
      if ((mode_reg == MODE_CURRENT || mode_reg == MODE_VOLTAGE) && !supplies_ok) begin
         applied_mode = MODE_RETRACT;
      end
   end

   always_comb begin
      next_mode_reg = mode_reg;
      next_cmd_high = cmd_high;
      next_cmd_low = cmd_low;
      next_adc_ctrl = adc_ctrl;
      next_dac_code = dac_code_o;
      next_trip_flag = trip_flag;
      if (is_write(wr_strobe, addr, REG_MODE)) begin
         next_mode_reg = wr_data[MODE_W-1:0];
      end
      if (is_write(wr_strobe, addr, REG_CMD_HIGH)) begin
         // upper bits wait in the shadow; gain applies at once
         next_cmd_high = wr_data;
      end
      if (is_write(wr_strobe, addr, REG_CMD_LOW)) begin
         next_cmd_low = wr_data;
         next_dac_code = {cmd_high[6:0], wr_data};
      end
      if (is_write(wr_strobe, addr, REG_ADC_CTRL)) begin
         next_adc_ctrl = wr_data;
      end
      // status read clears the trip flag, a new trip in that cycle wins
      if (is_write(rd_strobe, addr, REG_CAL_STATUS)) begin
         next_trip_flag = 1'b0;
      end
      if (trip_event) begin
         next_trip_flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_reg <= MODE_RETRACT;
         cmd_high <= CMD_HIGH_RESET;
         cmd_low <= CMD_LOW_RESET;
         adc_ctrl <= ADC_CTRL_RESET;
         trip_flag <= 1'b0;
         dac_code_o <= {CMD_W{1'b0}};
      end else begin
         mode_reg <= next_mode_reg;
         cmd_high <= next_cmd_high;
         cmd_low <= next_cmd_low;
         adc_ctrl <= next_adc_ctrl;
         trip_flag <= next_trip_flag;
         dac_code_o <= next_dac_code;
      end
   end

   // converter sequencer cycles current, voltage, back-emf, auxiliary
   always_comb begin
      next_adc_state = adc_state;
      next_adc_channel = adc_channel_o;
      adc_start_o = 1'b0;
      case (adc_state)
         ADC_IDLE: begin
            if (adc_ctrl[ADC_RUN_BIT]) begin
               adc_start_o = 1'b1;
               next_adc_state = ADC_BUSY;
            end
         end
         ADC_BUSY: begin
            if (adc_done_i) begin
               next_adc_state = ADC_STORE;
            end
         end
         ADC_STORE: begin
            next_adc_channel = adc_channel_o + 2'h1;
            next_adc_state = ADC_IDLE;
         end
         default: begin
            next_adc_state = ADC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         adc_state <= ADC_IDLE;
         adc_channel_o <= 2'h0;
      end else begin
         adc_state <= next_adc_state;
         adc_channel_o <= next_adc_channel;
      end
   end

   // result memory; no reset needed, reads before a conversion are don't-care
   always_ff @(posedge core_clk_i) begin
      if (adc_state == ADC_BUSY && adc_done_i) begin
         adc_mem[adc_channel_o] <= adc_result_i;
      end
   end

   // high byte read snapshots the low byte so the pair never tears
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         adc_low_hold <= {ADC_W{1'b0}};
      end else if (rd_strobe && addr >= REG_ADC_BASE && addr <= REG_ADC_LAST && !addr[0]) begin
         adc_low_hold <= adc_mem[addr[2:1]];
      end
   end

   always_comb begin
      rd_data = 8'h00;
      if (addr == REG_CAL_STATUS) begin
         rd_data[TRIP_BIT] = trip_flag;
         rd_data[SUPPLY12_BIT] = async_s2[0];
         rd_data[SUPPLY5_BIT] = async_s2[1];
      end else if (addr == REG_MODE) begin
         rd_data = {5'h00, mode_reg};
      end else if (addr == REG_CMD_HIGH) begin
         rd_data = cmd_high;
      end else if (addr == REG_CMD_LOW) begin
         rd_data = cmd_low;
      end else if (addr == REG_ADC_CTRL) begin
         rd_data = adc_ctrl;
      end else if (addr >= REG_ADC_BASE && addr <= REG_ADC_LAST) begin
         if (!addr[0]) begin
            rd_data = {6'h00, adc_mem[addr[2:1]][ADC_W-1:8]};
         end else begin
            rd_data = adc_low_hold[7:0];
         end
      end
   end

   // mode decode into analog switch and stage controls
   assign actuator_mode_o = applied_mode;
   assign sense_gain_select_o = cmd_high[GAIN_BIT];
   assign converter_scale_select_o = adc_ctrl[SCALE_BIT];
   assign power_stage_tristate_o = (applied_mode == MODE_TRISTATE)
                                 || (applied_mode == MODE_CALIBRATE)
                                 || (applied_mode > MODE_CALIBRATE);
   assign bridge_brake_o = (applied_mode == MODE_BRAKE);
   assign retract_enable_o = (applied_mode == MODE_RETRACT);
   assign sense_amp_tristate_o = (applied_mode == MODE_VOLTAGE);
   assign error_amp_tristate_o = (applied_mode == MODE_VOLTAGE);
   assign direct_drive_switch_o = (applied_mode == MODE_VOLTAGE);
   assign compensation_disconnect_switch_o = (applied_mode == MODE_CALIBRATE);

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_reset_retract;
      !$past(rst_n_i) |-> (mode_reg == MODE_RETRACT) && retract_enable_o;
   endproperty
   a_reset_retract: assert property (p_reset_retract)
      else $error("mode not retract after reset");

   property p_mode_write;
      wr_strobe && addr == REG_MODE |=> mode_reg == $past(wr_data[MODE_W-1:0]);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("mode write not taken");

   property p_high_holds;
      wr_strobe && addr == REG_CMD_HIGH |=> $stable(dac_code_o);
   endproperty
   a_high_holds: assert property (p_high_holds)
      else $error("upper write moved converter");

   property p_low_applies;
      wr_strobe && addr == REG_CMD_LOW
         |=> dac_code_o == {$past(cmd_high[6:0]), $past(wr_data)};
   endproperty
   a_low_applies: assert property (p_low_applies)
      else $error("lower write not applied with shadow");

   property p_gain;
      wr_strobe && addr == REG_CMD_HIGH |=> sense_gain_select_o == $past(wr_data[GAIN_BIT]);
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain bit not applied");

   property p_voltage;
      applied_mode == MODE_VOLTAGE |-> direct_drive_switch_o && sense_amp_tristate_o
         && error_amp_tristate_o && !compensation_disconnect_switch_o;
   endproperty
   a_voltage: assert property (p_voltage)
      else $error("voltage mode routing wrong");

   property p_calibrate;
      applied_mode == MODE_CALIBRATE |-> power_stage_tristate_o
         && compensation_disconnect_switch_o && !sense_amp_tristate_o;
   endproperty
   a_calibrate: assert property (p_calibrate)
      else $error("calibration routing wrong");

   property p_trip;
      trip_event |=> trip_flag [*1] ##0 (rd_data[TRIP_BIT] || addr != REG_CAL_STATUS);
   endproperty
   a_trip: assert property (p_trip)
      else $error("comparator trip not flagged");

   property p_supplies;
      !supplies_ok |-> actuator_mode_o != MODE_CURRENT && actuator_mode_o != MODE_VOLTAGE;
   endproperty
   a_supplies: assert property (p_supplies)
      else $error("assisted drive without supplies");

   property p_adc_store;
      adc_state == ADC_BUSY && adc_done_i |=> adc_mem[$past(adc_channel_o)] == $past(adc_result_i);
   endproperty
   a_adc_store: assert property (p_adc_store)
      else $error("conversion result not stored");

   property p_scale;
      wr_strobe && addr == REG_ADC_CTRL
         |=> converter_scale_select_o == $past(wr_data[SCALE_BIT]);
   endproperty
   a_scale: assert property (p_scale)
      else $error("range select not applied");
endmodule : vcm_dac_mode_control
`default_nettype wire

// [dv/serial_master_model.sv]
// Purpose: controller side of the three-wire register port
// Assumes: serial clock idles low, 160 ns period, 20 ns core clock
// Notes: data pin released for the reply half of a read frame
`timescale 1ns/100ps
`default_nettype none
module serial_master_model (
   input wire logic core_clk_i,
   input wire logic line_i,
   output logic serial_clk_o,
   output logic serial_enable_o,
   output logic data_o,
   output logic data_oe_n_o,
   output logic rd_valid_o,
   output logic [7:0] rd_byte_o
);
   initial begin
      serial_clk_o = 1'b0;
      serial_enable_o = 1'b0;
      data_o = 1'b0;
      data_oe_n_o = 1'b1;
      rd_valid_o = 1'b0;
      rd_byte_o = 8'h00;
   end

   task automatic half_period();
      repeat (4) @(negedge core_clk_i);
   endtask : half_period

   // read flag, 7 address bits, 8 data bits, msb first
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata);
      logic [15:0] word;
      logic [7:0] got;
      word = {rd, addr, wdata};
      got = 8'h00;
      serial_enable_o = 1'b1;
      for (int i = 15; i >= 0; i--) begin
         data_oe_n_o = rd && (i < 8);
         data_o = word[i];
         half_period();
         serial_clk_o = 1'b1;
         // sample late: the reply bit moves a few core clocks after the fall
         half_period();
         got = {got[6:0], line_i};
         serial_clk_o = 1'b0;
      end
      half_period();
      serial_enable_o = 1'b0;
      data_oe_n_o = 1'b1;
      rd_byte_o = got;
      rd_valid_o = rd;
      @(negedge core_clk_i);
      rd_valid_o = 1'b0;
      // gap well above the three core clocks between frames
      repeat (8) @(negedge core_clk_i);
   endtask : xfer
endmodule : serial_master_model
`default_nettype wire

// [dv/tb_vcm_dac_mode_control.sv]
// Purpose: self-checking bench for the actuator mode and command block
// Assumes: 50 MHz core clock, inputs move on the falling edge
// Notes: read replies are checked against a queue of expected bytes
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_vcm_dac_mode_control;
   import vcm_pkg::*;
   logic core_clk_i, rst_n_i, serial_clk_i, serial_enable_i, serial_data_i;
   logic serial_data_o, serial_data_oe_n_o, supply12_ok_i, supply5_ok_i, cal_comparator_i;
   logic adc_done_i = 1'b0, adc_start_o, converter_scale_select_o, sense_gain_select_o;
   logic [ADC_W-1:0] adc_result_i = 10'h000;
   logic [1:0] adc_channel_o;
   logic [1:0] adc_wait = 2'h0;
   logic [CMD_W-1:0] dac_code_o, cur;
   logic [MODE_W-1:0] actuator_mode_o;
   logic power_stage_tristate_o, bridge_brake_o, retract_enable_o, sense_amp_tristate_o;
   logic error_amp_tristate_o, direct_drive_switch_o, compensation_disconnect_switch_o;
   logic m_data, m_oe_n, rd_valid, last_line = 1'b0;
   logic [7:0] rd_byte, exp_v, rnd, hi, lo;
   logic [7:0] exp_q[$];
   int bad_count, cmp_count, cycles;

   vcm_dac_mode_control dut (.core_clk_i, .rst_n_i, .serial_clk_i, .serial_enable_i,
      .serial_data_i, .serial_data_o, .serial_data_oe_n_o, .supply12_ok_i, .supply5_ok_i,
      .cal_comparator_i, .adc_done_i, .adc_result_i, .adc_start_o, .adc_channel_o,
      .converter_scale_select_o, .dac_code_o, .sense_gain_select_o, .actuator_mode_o,
      .power_stage_tristate_o, .bridge_brake_o, .retract_enable_o, .sense_amp_tristate_o,
      .error_amp_tristate_o, .direct_drive_switch_o, .compensation_disconnect_switch_o);

   serial_master_model mcu (.core_clk_i, .line_i(serial_data_i),
      .serial_clk_o(serial_clk_i), .serial_enable_o(serial_enable_i), .data_o(m_data),
      .data_oe_n_o(m_oe_n), .rd_valid_o(rd_valid), .rd_byte_o(rd_byte));

   // nobody driving: line toggles so a stale bit cannot pass
   always_comb serial_data_i = !serial_data_oe_n_o ? serial_data_o :
      (!m_oe_n ? m_data : ~last_line);
   always @(posedge core_clk_i) last_line <= serial_data_i;

   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end

   // converter answers three cycles after start; result tells channels apart
   always @(negedge core_clk_i) begin
      adc_done_i <= 1'b0;
      if (adc_start_o) adc_wait <= 2'h3;
      else if (adc_wait != 2'h0) begin
         adc_wait <= adc_wait - 2'h1;
         if (adc_wait == 2'h1) begin
            adc_done_i <= 1'b1;
            adc_result_i <= {~adc_channel_o, 8'h40 + {6'h00, adc_channel_o}};
         end
      end
   end

   always @(posedge core_clk_i) begin
      if (rd_valid) begin
         exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
         `CHK("read data", exp_v, rd_byte)
      end
   end

   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   function automatic logic [6:0] decode_exp(input logic [2:0] m);
      return {m == 3'h1 || m > 3'h4, m == 3'h2, m == 3'h0, m == 3'h4, m == 3'h4, m == 3'h4,
         m == 3'h5};
   endfunction : decode_exp

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      mcu.xfer(1'b0, a, d);
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      mcu.xfer(1'b1, a, 8'h00);
   endtask : rd

   task automatic check_mode(input logic [2:0] m);
      `CHK("mode", m, actuator_mode_o)
      `CHK("decode", decode_exp(m), {power_stage_tristate_o, bridge_brake_o, retract_enable_o,
         sense_amp_tristate_o, error_amp_tristate_o, direct_drive_switch_o,
         compensation_disconnect_switch_o})
   endtask : check_mode

   task automatic settle();
      repeat (4) @(negedge core_clk_i);
   endtask : settle

   initial begin
      rst_n_i = 1'b0;
      supply12_ok_i = 1'b1;
      supply5_ok_i = 1'b1;
      cal_comparator_i = 1'b0;
      rnd = 8'h4B;
      repeat (12) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      settle();
      check_mode(MODE_RETRACT);
      `CHK("dac after reset", 15'h0000, dac_code_o)
      rd(REG_CAL_STATUS, 8'h03);
      rd(REG_CMD_HIGH, CMD_HIGH_RESET);
      rd(REG_CMD_LOW, CMD_LOW_RESET);
      for (int m = 0; m < 8; m++) begin
         wr(REG_MODE, 8'(m));
         check_mode(3'(m));
      end
      wr(REG_MODE, 8'h03);
      wr(REG_CMD_LOW, 8'h34);
      `CHK("low alone", 15'h0034, dac_code_o)
      wr(REG_CMD_HIGH, 8'hBF);
      `CHK("high held", 15'h0034, dac_code_o)
      `CHK("gain", 1'b1, sense_gain_select_o)
      wr(REG_CMD_LOW, 8'hFF);
      `CHK("full positive", 15'h3FFF, dac_code_o)
      wr(REG_CMD_HIGH, 8'h40);
      wr(REG_CMD_LOW, 8'h00);
      `CHK("full negative", 15'h4000, dac_code_o)
      cur = 15'h4000;
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         hi = rnd;
         rnd = lfsr(rnd);
         lo = rnd;
         wr(REG_CMD_HIGH, hi);
         `CHK("shadow held", cur, dac_code_o)
         `CHK("gain bit", hi[7], sense_gain_select_o)
         wr(REG_CMD_LOW, lo);
         cur = {hi[6:0], lo};
         `CHK("command", cur, dac_code_o)
         rd(REG_CMD_HIGH, hi);
         rd(REG_CMD_LOW, lo);
      end
      // comparator edge outside calibration must not trip
      cal_comparator_i = 1'b1;
      settle();
      rd(REG_CAL_STATUS, 8'h03);
      wr(REG_MODE, 8'h05);
      // controller steps the command up from 15'h7FFE through 15'h7FFF to zero
      wr(REG_CMD_HIGH, 8'h7F);
      wr(REG_CMD_LOW, 8'hFE);
      wr(REG_CMD_LOW, 8'hFF);
      wr(REG_CMD_HIGH, 8'h00);
      wr(REG_CMD_LOW, 8'h00);
      cal_comparator_i = 1'b0;
      settle();
      `CHK("trip code", 15'h0000, dac_code_o)
      rd(REG_CAL_STATUS, 8'h43);
      rd(REG_CAL_STATUS, 8'h03);
      wr(REG_MODE, 8'h03);
      supply5_ok_i = 1'b0;
      settle();
      check_mode(MODE_RETRACT);
      rd(REG_CAL_STATUS, 8'h01);
      wr(REG_MODE, 8'h04);
      supply5_ok_i = 1'b1;
      supply12_ok_i = 1'b0;
      settle();
      check_mode(MODE_RETRACT);
      supply12_ok_i = 1'b1;
      settle();
      check_mode(MODE_VOLTAGE);
      wr(REG_ADC_CTRL, 8'h03);
      `CHK("scaled", 1'b1, converter_scale_select_o)
      for (int n = 0; n < 4; n++) begin
         rd(REG_ADC_BASE + 7'(2 * n), {6'h00, ~2'(n)});
         rd(REG_ADC_BASE + 7'(2 * n + 1), 8'h40 + 8'(n));
      end
      // stop-held actuator: step the command down in current mode, reading current
      wr(REG_MODE, 8'h03);
      check_mode(MODE_CURRENT);
      wr(REG_CMD_HIGH, 8'h00);
      for (int s = 2; s >= 0; s--) begin
         wr(REG_CMD_LOW, 8'(s));
         `CHK("step down", 15'(s), dac_code_o)
         rd(REG_ADC_BASE, 8'h03);
         rd(REG_ADC_BASE + 7'h01, 8'h40);
      end
      wr(REG_ADC_CTRL, 8'h00);
      `CHK("unscaled", 1'b0, converter_scale_select_o)
      wr(7'h7F, 8'h55);
      rd(7'h7F, 8'h00);
      rd(REG_CMD_LOW, 8'h00);
      tally_and_finish();
   end
endmodule : tb_vcm_dac_mode_control
`default_nettype wire
